// [ptptc_top.sv]
// Purpose: Precision time clock with step, capture, load and rate trim, AXI4-Lite slave
// Assumes: aclk at 250 MHz, synchronous active-low reset, rate inputs synchronous
// Notes: Trigger actions happen the cycle after the control write, then self-clear
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// - Step bit adds/subtracts nanoseconds, then self-clears
// - Step direction 1 adds, 0 subtracts
// - Capture bit samples running time, self-clears
// - Load bit loads running time, self-clears
// - Continuous bit trims rate every reference cycle
// - Enable resets to 1; 0 freezes clock
// - Reset bit clears time clock, self-clears
// - Nanoseconds 30 bits, high bits 15:14 unused
// - Seconds 32 bits, fully writable
// - Advance every 40 ns; phase marks 8 ns
// - Phase codes 0..4 only, 5..7 unused
// - Time register writes zero the phase
// - Rate direction 1 slows, 0 speeds
// - Rate is 30 bits of 2^-32 ns
// - Zero rate disables frequency adjustment
module ptptc_top
   import ptptc_pkg::*;
(
   input wire logic aclk, // Bus and time clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [ptptc_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic [2:0] s_axi_awprot, // Write protection, unused
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [ptptc_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic [2:0] s_axi_arprot, // Read protection, unused
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [ptptc_pkg::RATE_W-1:0] rate_value, // Rate trim, 2^-32 ns units
   input wire logic rate_direction // 1 slows the clock, 0 speeds it
);
   import ptptc_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [ADDR_W-1:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic aw_have_ff;
   logic w_have_ff;
   logic [CTL_W-1:0] ctl_ff;
   logic [NS_W-1:0] ns_reg_ff;
   logic [SEC_W-1:0] sec_reg_ff;
   logic [PHASE_W-1:0] phase_reg_ff;
   logic [NS_W-1:0] rt_ns_ff;
   logic [SEC_W-1:0] rt_sec_ff;
   logic [PHASE_W-1:0] rt_phase_ff;
   logic [1:0] sub_ff;
   logic [FRAC_W-1:0] frac_ff;
   logic do_write;
   logic [ADDR_W-1:0] widx;
   logic [ADDR_W-1:0] ridx;
   logic wmapped;
   logic [15:0] wmask;
   logic [15:0] wval;
   logic time_reg_write;
   logic ref_tick;
   logic adj_active;
   logic [FRAC_W:0] frac_sum;
   logic [FRAC_W:0] frac_diff;
   logic [FRAC_W-1:0] nxt_frac;
   logic [NS_W-1:0] tick_inc;
   logic [NS_W:0] ns_sum;
   logic [NS_W-1:0] nxt_tick_ns;
   logic nxt_tick_carry;
   logic [NS_W:0] step_sum;
   logic [NS_W-1:0] nxt_step_ns;
   logic [SEC_W-1:0] nxt_step_sec;
   logic [31:0] nxt_rdata;
   logic nxt_rmapped;

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // ****************************************
   // Write channel handshakes
   // ****************************************
   assign do_write = aw_have_ff & w_have_ff & ~bvalid_ff;
   assign widx = waddr_ff >> BYTE_SHIFT;
   assign wmask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   assign wval = wdata_ff[15:0];

   always_comb
   begin
      case (widx)
         IDX_CONTROL, IDX_NS_LOW, IDX_NS_HIGH, IDX_SEC_LOW, IDX_SEC_HIGH, IDX_PHASE:
            wmapped = (waddr_ff[1:0] == 2'h0);
         default:
            wmapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_ff <= 1'b1;
         aw_have_ff <= 1'b0;
         waddr_ff <= '0;
      end
      else if (s_axi_awvalid && awready_ff)
      begin
         awready_ff <= 1'b0;
         aw_have_ff <= 1'b1;
         waddr_ff <= s_axi_awaddr;
      end
      else if (do_write)
         aw_have_ff <= 1'b0;
      else if (bvalid_ff && s_axi_bready)
         awready_ff <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready_ff <= 1'b1;
         w_have_ff <= 1'b0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
      end
      else if (s_axi_wvalid && wready_ff)
      begin
         wready_ff <= 1'b0;
         w_have_ff <= 1'b1;
         wdata_ff <= s_axi_wdata;
         wstrb_ff <= s_axi_wstrb;
      end
      else if (do_write)
         w_have_ff <= 1'b0;
      else if (bvalid_ff && s_axi_bready)
         wready_ff <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wmapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_ff <= 1'b0;
   end

   // ****************************************
   // Control register
   // ****************************************
   // Triggers written as 1 act on the next edge and clear there
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctl_ff <= CTL_RESET;
      else if (do_write && wmapped && widx == IDX_CONTROL)
         ctl_ff <= (ctl_ff & ~wmask[CTL_W-1:0]) | (wval[CTL_W-1:0] & wmask[CTL_W-1:0]);
      else
         ctl_ff <= ctl_ff & ~CTL_SELF_CLEAR;
   end

   // ****************************************
   // Software time registers
   // ****************************************
   assign time_reg_write = do_write && wmapped && (widx == IDX_NS_LOW ||
      widx == IDX_NS_HIGH || widx == IDX_SEC_LOW || widx == IDX_SEC_HIGH);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ns_reg_ff <= NS_RESET;
         sec_reg_ff <= SEC_RESET;
         phase_reg_ff <= PHASE_RESET;
      end
      else if (ctl_ff[BIT_CAPTURE])
      begin
         ns_reg_ff <= rt_ns_ff;
         sec_reg_ff <= rt_sec_ff;
         phase_reg_ff <= rt_phase_ff;
      end
      else if (do_write && wmapped)
      begin
         case (widx)
            IDX_NS_LOW:
               ns_reg_ff[15:0] <= (ns_reg_ff[15:0] & ~wmask) | (wval & wmask);
            IDX_NS_HIGH:
               ns_reg_ff[NS_W-1:16] <= (ns_reg_ff[NS_W-1:16] & ~wmask[NS_HIGH_W-1:0]) |
                  (wval[NS_HIGH_W-1:0] & wmask[NS_HIGH_W-1:0]);
            IDX_SEC_LOW:
               sec_reg_ff[15:0] <= (sec_reg_ff[15:0] & ~wmask) | (wval & wmask);
            IDX_SEC_HIGH:
               sec_reg_ff[31:16] <= (sec_reg_ff[31:16] & ~wmask) | (wval & wmask);
            IDX_PHASE:
               if (wmask[0] && wval[PHASE_W-1:0] <= PHASE_LAST)
                  phase_reg_ff <= wval[PHASE_W-1:0];
            default:
               phase_reg_ff <= phase_reg_ff;
         endcase
         if (time_reg_write)
            phase_reg_ff <= PHASE_RESET;
      end
   end

   // ****************************************
   // Reference cycle and rate trim arithmetic
   // ****************************************
   assign ref_tick = ctl_ff[BIT_CLK_ENABLE] && rt_phase_ff == PHASE_LAST &&
      sub_ff == SUB_LAST;
   assign adj_active = ctl_ff[BIT_CONT_ADJ] && rate_value != '0;
   assign frac_sum = {1'b0, frac_ff} + {3'h0, rate_value};
   assign frac_diff = {1'b0, frac_ff} - {3'h0, rate_value};

   always_comb
   begin
      nxt_frac = frac_ff;
      tick_inc = REF_STEP;
      if (adj_active)
      begin
         if (rate_direction)
         begin
            nxt_frac = frac_diff[FRAC_W-1:0];
            tick_inc = frac_diff[FRAC_W] ? REF_STEP - 30'h1 : REF_STEP;
         end
         else
         begin
            nxt_frac = frac_sum[FRAC_W-1:0];
            tick_inc = frac_sum[FRAC_W] ? REF_STEP + 30'h1 : REF_STEP;
         end
      end
   end

   always_comb
   begin
      ns_sum = {1'b0, rt_ns_ff} + {1'b0, tick_inc};
      nxt_tick_carry = ns_sum >= {1'b0, NS_PER_SEC};
      nxt_tick_ns = nxt_tick_carry ? NS_W'(ns_sum - {1'b0, NS_PER_SEC}) : ns_sum[NS_W-1:0];
   end

   // ****************************************
   // Step adjustment arithmetic
   // ****************************************
   always_comb
   begin
      step_sum = {1'b0, rt_ns_ff} + {1'b0, ns_reg_ff};
      nxt_step_ns = step_sum[NS_W-1:0];
      nxt_step_sec = rt_sec_ff;
      if (ctl_ff[BIT_STEP_DIR])
      begin
         if (step_sum >= {1'b0, NS_PER_SEC})
         begin
            nxt_step_ns = NS_W'(step_sum - {1'b0, NS_PER_SEC});
            nxt_step_sec = rt_sec_ff + 32'h1;
         end
      end
      else if (rt_ns_ff < ns_reg_ff)
      begin
         nxt_step_ns = rt_ns_ff + NS_PER_SEC - ns_reg_ff;
         nxt_step_sec = rt_sec_ff - 32'h1;
      end
      else
         nxt_step_ns = rt_ns_ff - ns_reg_ff;
   end

   // ****************************************
   // Running time clock
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn || ctl_ff[BIT_CLK_RESET])
      begin
         rt_ns_ff <= NS_RESET;
         rt_sec_ff <= SEC_RESET;
         rt_phase_ff <= PHASE_RESET;
         sub_ff <= 2'h0;
         frac_ff <= '0;
      end
      else if (ctl_ff[BIT_LOAD])
      begin
         rt_ns_ff <= ns_reg_ff;
         rt_sec_ff <= sec_reg_ff;
         rt_phase_ff <= phase_reg_ff;
         sub_ff <= 2'h0;
      end
      else if (ctl_ff[BIT_STEP])
      begin
         rt_ns_ff <= nxt_step_ns;
         rt_sec_ff <= nxt_step_sec;
      end
      else if (ctl_ff[BIT_CLK_ENABLE])
      begin
         if (sub_ff == SUB_LAST)
         begin
            sub_ff <= 2'h0;
            rt_phase_ff <= (rt_phase_ff == PHASE_LAST) ? PHASE_RESET :
               rt_phase_ff + 3'h1;
         end
         else
            sub_ff <= sub_ff + 2'h1;
         if (ref_tick)
         begin
            rt_ns_ff <= nxt_tick_ns;
            frac_ff <= nxt_frac;
            if (nxt_tick_carry)
               rt_sec_ff <= rt_sec_ff + 32'h1;
         end
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   assign ridx = s_axi_araddr >> BYTE_SHIFT;

   always_comb
   begin
      nxt_rdata = 32'h0;
      nxt_rmapped = (s_axi_araddr[1:0] == 2'h0);
      case (ridx)
         IDX_CONTROL:
            nxt_rdata[CTL_W-1:0] = ctl_ff;
         IDX_NS_LOW:
            nxt_rdata[15:0] = ns_reg_ff[15:0];
         IDX_NS_HIGH:
            nxt_rdata[NS_HIGH_W-1:0] = ns_reg_ff[NS_W-1:16];
         IDX_SEC_LOW:
            nxt_rdata[15:0] = sec_reg_ff[15:0];
         IDX_SEC_HIGH:
            nxt_rdata[15:0] = sec_reg_ff[31:16];
         IDX_PHASE:
            nxt_rdata[PHASE_W-1:0] = phase_reg_ff;
         default:
            nxt_rmapped = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= RESP_OKAY;
      end
      else if (s_axi_arvalid && arready_ff)
      begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= nxt_rmapped ? nxt_rdata : 32'h0;
         rresp_ff <= nxt_rmapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
      begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

endmodule

// [ptptc_pkg.sv]
// Purpose: Constants shared by the time clock control block
// Assumes: 250 MHz bus clock, registers one per aligned 32-bit word
// Notes: Register offsets are word indices; byte address is four times the index
package ptptc_pkg;
   // ****************************************
   // Register indices and address decode
   // ****************************************
   localparam int ADDR_W = 16;
   localparam logic [ADDR_W-1:0] IDX_CONTROL = 16'h0600;
   localparam logic [ADDR_W-1:0] IDX_NS_LOW = 16'h0604;
   localparam logic [ADDR_W-1:0] IDX_NS_HIGH = 16'h0606;
   localparam logic [ADDR_W-1:0] IDX_SEC_LOW = 16'h0608;
   localparam logic [ADDR_W-1:0] IDX_SEC_HIGH = 16'h060a;
   localparam logic [ADDR_W-1:0] IDX_PHASE = 16'h060c;
   localparam int BYTE_SHIFT = 2;

   // ****************************************
   // Control field positions and reset value
   // ****************************************
   localparam int CTL_W = 7;
   localparam int BIT_CLK_RESET = 0;
   localparam int BIT_CLK_ENABLE = 1;
   localparam int BIT_CONT_ADJ = 2;
   localparam int BIT_LOAD = 3;
   localparam int BIT_CAPTURE = 4;
   localparam int BIT_STEP_DIR = 5;
   localparam int BIT_STEP = 6;
   localparam logic [CTL_W-1:0] CTL_RESET = 7'h02;
   localparam logic [CTL_W-1:0] CTL_SELF_CLEAR = 7'h59;

   // ****************************************
   // Field widths and reset values
   // ****************************************
   localparam int NS_W = 30;
   localparam int SEC_W = 32;
   localparam int PHASE_W = 3;
   localparam int RATE_W = 30;
   localparam int FRAC_W = 32;
   localparam int NS_HIGH_W = NS_W - 16;
   localparam logic [NS_W-1:0] NS_RESET = 30'h0;
   localparam logic [SEC_W-1:0] SEC_RESET = 32'h0;
   localparam logic [PHASE_W-1:0] PHASE_RESET = 3'h0;
   localparam logic [PHASE_W-1:0] PHASE_LAST = 3'h4;
   localparam logic [NS_W-1:0] NS_PER_SEC = 30'h3b9aca00;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int PHASE_NS = 8;
   localparam int REF_PERIOD_NS = 40;
   localparam int PHASE_CYCLES = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] SUB_LAST = 2'(PHASE_CYCLES - 1);
   localparam logic [NS_W-1:0] REF_STEP = 30'(REF_PERIOD_NS);

   // ****************************************
   // Bus responses
   // ****************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [ptptc_properties.sv]
// Purpose: Bus handshake checks for the time clock control block
// Assumes: Single clock domain, synchronous active-low reset
// Notes: Bound to ptptc_top, watches its ports only
`timescale 1ns/1ps
module ptptc_checker (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic s_axi_awvalid, // Write address valid
   input wire logic s_axi_awready, // Write address ready
   input wire logic s_axi_wvalid, // Write data valid
   input wire logic s_axi_wready, // Write data ready
   input wire logic [1:0] s_axi_bresp, // Write response
   input wire logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [ptptc_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   input wire logic s_axi_arready, // Read address ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic [1:0] s_axi_rresp, // Read response
   input wire logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);
   import ptptc_pkg::*;
   // ****************************************
   // Handshake properties
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready) |=> ##1 s_axi_bvalid) else $error("write answer late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
      && s_axi_awready && s_axi_wready) else $error("write channel not freed");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer moved");
   a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
      && s_axi_arready) else $error("read channel not freed");
   a_bad_addr: assert property ((s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad address ok");
   a_reset_idle: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid) else $error("not idle after reset");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind ptptc_top ptptc_checker ptptc_checker_inst (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready);

// [test_ptptc_top.sv]
// Purpose: Register level test of the time clock control block
// Assumes: Byte address is four times the register index
// Notes: Clock frozen before each capture so times are exact
`timescale 1ns/1ps
module test_ptptc_top;
   import ptptc_pkg::*;
   logic aclk, aresetn, awv, wv, bready, arv, rready, rate_direction;
   logic awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d, ns, sec, ph;
   logic [1:0] bresp, rresp, rs;
   logic [RATE_W-1:0] rate_value;
   int n_fail = 0;
   int compares = 0;
   ptptc_top ptptc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .rate_value(rate_value), .rate_direction(rate_direction));
   // ****************************************
   // Bus tasks
   // ****************************************
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] idx, input logic [31:0] v);
      bit done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= idx << BYTE_SHIFT;
      wdata <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (awv && awready) awv <= 1'b0;
         if (wv && wready) wv <= 1'b0;
         if (bvalid)
         begin
            done = 1'b1;
            rs = bresp;
            bready <= 1'b0;
         end
      end
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      bit done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (arv && arready) arv <= 1'b0;
         if (rvalid)
         begin
            done = 1'b1;
            d = rdata;
            rs = rresp;
            rready <= 1'b0;
         end
      end
   endtask
   task automatic rdchk(input logic [ADDR_W-1:0] idx, input logic [31:0] exp);
      rd(idx << BYTE_SHIFT);
      chk(d, exp);
      chk(32'(rs), 32'(RESP_OKAY));
   endtask
   task automatic setns(input logic [31:0] v);
      wr(IDX_NS_LOW, {16'h0, v[15:0]});
      wr(IDX_NS_HIGH, {16'h0, v[31:16]});
   endtask
   task automatic snap();
      wr(IDX_CONTROL, 32'h10);
      rdchk(IDX_CONTROL, 32'h0);
      rd(IDX_NS_LOW << BYTE_SHIFT);
      ns[15:0] = d[15:0];
      rd(IDX_NS_HIGH << BYTE_SHIFT);
      ns[31:16] = d[15:0];
      rd(IDX_SEC_LOW << BYTE_SHIFT);
      sec[15:0] = d[15:0];
      rd(IDX_SEC_HIGH << BYTE_SHIFT);
      sec[31:16] = d[15:0];
      rd(IDX_PHASE << BYTE_SHIFT);
      ph = d;
      chk(32'(ph <= 32'h4), 32'h1);
   endtask
   task automatic run(input logic [31:0] c, input logic [RATE_W-1:0] r, input logic dir);
      rate_value <= r;
      rate_direction <= dir;
      wr(IDX_CONTROL, 32'h01);
      wr(IDX_CONTROL, c);
      repeat (400) @(posedge aclk);
      wr(IDX_CONTROL, 32'h0);
      snap();
   endtask
   task automatic test_done();
      if (n_fail == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // Test sequence
   // ****************************************
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      test_done();
   end
   initial
   begin
      aresetn = 1'b0;
      {awv, wv, bready, arv, rready, rate_direction} = 6'h0;
      {awaddr, araddr, wdata, rate_value} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      wr(16'h0601, 32'h0);
      chk(32'(rs), 32'(RESP_SLVERR));
      rdchk(IDX_CONTROL, 32'h2);
      rdchk(IDX_SEC_HIGH, 32'h0);
      rd(16'h1802);
      chk({d[31:2], rs}, 32'(RESP_SLVERR));
      wr(IDX_CONTROL, 32'h0);
      chk(32'(rs), 32'(RESP_OKAY));
      wr(IDX_NS_HIGH, 32'hffff);
      rdchk(IDX_NS_HIGH, 32'h3fff);
      wr(IDX_SEC_HIGH, 32'hffff);
      rdchk(IDX_SEC_HIGH, 32'hffff);
      wr(IDX_PHASE, 32'h3);
      rdchk(IDX_PHASE, 32'h3);
      wr(IDX_SEC_LOW, 32'h5);
      rdchk(IDX_PHASE, 32'h0);
      wr(IDX_PHASE, 32'h7);
      rdchk(IDX_PHASE, 32'h0);
      wr(IDX_SEC_HIGH, 32'h0);
      setns(32'd1000);
      wr(IDX_PHASE, 32'h2);
      wr(IDX_CONTROL, 32'h08);
      rdchk(IDX_CONTROL, 32'h0);
      snap();
      chk(32'({ns, sec, ph} == {32'd1000, 32'd5, 32'h2}), 32'h1);
      setns(32'd300);
      wr(IDX_CONTROL, 32'h60);
      rdchk(IDX_CONTROL, 32'h20);
      snap();
      chk(ns, 32'd1300);
      setns(32'd2000);
      wr(IDX_CONTROL, 32'h40);
      snap();
      chk(32'({ns, sec} == {32'(NS_PER_SEC) - 32'd700, 32'd4}), 32'h1);
      setns(32'd1000);
      wr(IDX_CONTROL, 32'h60);
      snap();
      chk(32'({ns, sec} == {32'd300, 32'd5}), 32'h1);
      wr(IDX_CONTROL, 32'h01);
      rdchk(IDX_CONTROL, 32'h0);
      snap();
      chk(ns, 32'h0);
      chk(sec, 32'h0);
      run(32'h06, 30'h0, 1'b0);
      chk(ns % 40, 32'h0);
      chk(32'(ns >= 1600 && ns <= 1680), 32'h1);
      run(32'h06, 30'h3fffffff, 1'b0);
      chk(ns % 40, 32'(((64'(ns / 40)) * 64'h3fffffff) >> 32));
      run(32'h06, 30'h3fffffff, 1'b1);
      chk(32'(ns % 40 != 0), 32'h1);
      chk(32'(ns < 32'd1600), 32'h1);
      run(32'h02, 30'h3fffffff, 1'b0);
      chk(ns % 40, 32'h0);
      test_done();
   end
endmodule
